// >>> rtl/mie_consts.vh
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// wishbone register byte offsets
`define MIE_REG_CTRL 4'h0
`define MIE_REG_INSTR 4'h4
`define MIE_REG_ACC 4'h8
`define MIE_REG_STAT 4'hC
// ctrl fields
`define MIE_CTRL_RUN 0
// status byte fields
`define MIE_ST_C 0
`define MIE_ST_AC 1
`define MIE_ST_Z 2
`define MIE_ST_OV 3
`define MIE_ST_PDF 4
`define MIE_ST_TO 5
// opcode field [15:11]
`define MIE_OP_NOP 5'h00
`define MIE_OP_MOV_AM 5'h01
`define MIE_OP_MOV_MA 5'h02
`define MIE_OP_MOV_AX 5'h03
`define MIE_OP_CLRB 5'h04
`define MIE_OP_SETB 5'h05
`define MIE_OP_JMP 5'h06
`define MIE_OP_SZ 5'h07
`define MIE_OP_SZA 5'h08
`define MIE_OP_SZB 5'h09
`define MIE_OP_SNZB 5'h0A
`define MIE_OP_SIZ 5'h0B
`define MIE_OP_SDZ 5'h0C
`define MIE_OP_SKIP_AFTER_INCREMENT_TO_ACC 5'h0D
`define MIE_OP_SKIP_AFTER_DECREMENT_TO_ACC 5'h0E
`define MIE_OP_CALL 5'h0F
`define MIE_OP_RET 5'h10
`define MIE_OP_RETAX 5'h11
`define MIE_OP_RETURN_FROM_IRQ 5'h12
`define MIE_OP_TRDC 5'h13
`define MIE_OP_TRDL 5'h14
`define MIE_OP_CLRM 5'h15
`define MIE_OP_SETM 5'h16
`define MIE_OP_CLRWDT 5'h17
`define MIE_OP_WDT1 5'h18
`define MIE_OP_WDT2 5'h19
`define MIE_OP_SWAP 5'h1A
`define MIE_OP_NIBBLE_EXCHANGE_TO_ACC 5'h1B
`define MIE_OP_HALT 5'h1C
`define MIE_OP_ADD 5'h1D
`define MIE_OP_ADC 5'h1E
`define MIE_OP_AND 5'h1F
// sub-field bits for add/and group, pc low byte address, reset pc
`define MIE_SUB_MEM 10
`define MIE_SUB_IMM 9
`define MIE_PCL_ADDR 8'h02
`define MIE_RESET_PC 11'h000
`endif

// >>> rtl/mie_stack.v
`timescale 1ns/1ps
`default_nettype none
module mie_stack #(
  parameter AW = 11,
  parameter DEPTH_LOG2 = 3
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // push and pop
  input wire push,
  input wire pop,
  input wire [AW-1:0] push_data,
  // registered top of stack
  output reg [AW-1:0] top_r
);
  reg [AW-1:0] mem [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2-1:0] sp_r;
  wire [DEPTH_LOG2-1:0] sp_dec = sp_r - 1'b1;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sp_r <= {DEPTH_LOG2{1'b0}};
      top_r <= {AW{1'b0}};
    end else if (push) begin
      mem[sp_r] <= push_data;
      sp_r <= sp_r + 1'b1;
      top_r <= push_data;
    end else if (pop) begin
      // circular stack: overflow wraps, as on the small core
      sp_r <= sp_dec;
      top_r <= mem[sp_dec - 1'b1];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/mie_core.v
// Overview of operation
// - skip instructions take two cycles when skipping, one otherwise
// - writing pc low byte costs two cycles
// - pre-clear pair clears timeout and sleep flags only when consecutive
// - repeating first pre-clear alone does nothing
// - single clear resets watchdog, clears both flags, one cycle
// - call pushes return address, loads target, two cycles
// - jump and all returns take two cycles
// - table reads fetch word, high to lookup high, low to memory
// - add with carry to acc or memory, updates four flags
// - add without carry to acc or memory, updates four flags
// - add immediate to acc, updates four flags
// - and writes acc or memory, changes only zero flag
// - clear memory writes zero, no flag change
// - bit set/clear touches only chosen bit, no flags
// - moves copy value without touching flags
// - increment/decrement skip on zero, acc variants write acc
// - skip zero copy loads acc, skips when byte zero
// - bit tests skip on zero or nonzero bit
// - nibble exchange to memory or acc, one cycle
// - halt enters power down in one cycle, touches both flags
// - halt stops clock, clears watchdog, sets sleep, clears timeout
// - bit index selects positions zero to seven
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
module mie_core #(
  parameter AW = 11,
  parameter WDT_W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // program memory
  output reg [AW-1:0] pm_addr_r,
  input wire [15:0] pm_data,
  // data memory
  output reg [7:0] dm_addr_r,
  output reg [7:0] dm_wdata_r,
  output reg dm_we_r,
  input wire [7:0] dm_rdata,
  // watchdog, power state, table-read high byte and interrupt-return pulse
  output reg [WDT_W-1:0] watchdog_counter,
  output reg clk_stopped_r,
  output reg [7:0] lookup_high_byte,
  output reg return_from_irq_r
);
  localparam S_EXEC = 2'h0;
  localparam S_DUMMY = 2'h1;
  localparam S_HALT = 2'h2;

  reg [1:0] state_r;
  reg run_r;
  reg [15:0] instr_r;
  reg instr_pend_r;
  reg [7:0] working_register;
  reg c_r, half_carry_bit, z_r, signed_wrap_bit;
  reg watchdog_expired_bit, sleep_entered_bit;
  reg pre1_seen_r;
  reg pre2_seen_r;
  reg [AW-1:0] pc_r;
  reg [AW-1:0] pc_nxt;
  reg [1:0] state_nxt;
  reg [7:0] acc_nxt, mem_nxt;
  reg mem_we, c_nxt, ac_nxt, z_nxt, ov_nxt, skip;
  reg push, pop, wdt_clr, pre1_nxt, to_nxt, pdf_nxt, irq_ret;
  reg pre2_nxt;
  reg [8:0] sum;
  reg [4:0] lo_sum;

  wire [4:0] op = instr_r[15:11];
  wire [7:0] imm = instr_r[7:0];
  wire [2:0] bit_idx = instr_r[10:8];
  wire [AW-1:0] target = instr_r[AW-1:0];
  wire to_mem = instr_r[`MIE_SUB_MEM];
  wire use_imm = instr_r[`MIE_SUB_IMM];
  wire [7:0] opnd = use_imm ? imm : dm_rdata;
  wire [AW-1:0] stack_top;
  wire exec = (state_r == S_EXEC) && instr_pend_r && run_r;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [7:0] status_byte = {2'b00, watchdog_expired_bit, sleep_entered_bit,
    signed_wrap_bit, z_r, half_carry_bit, c_r};

  // return address formed here so the stack sees a plain bus
  wire [AW-1:0] ret_addr = pc_r + 1'b1;

  mie_stack #(.AW(AW), .DEPTH_LOG2(3)) u_stack (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(push),
    .pop(pop),
    .push_data(ret_addr),
    .top_r(stack_top)
  );

  always @* begin
    pc_nxt = pc_r + 1'b1;
    state_nxt = S_EXEC;
    acc_nxt = working_register;
    mem_nxt = dm_rdata;
    mem_we = 1'b0;
    c_nxt = c_r;
    ac_nxt = half_carry_bit;
    z_nxt = z_r;
    ov_nxt = signed_wrap_bit;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    wdt_clr = 1'b0;
    pre1_nxt = pre1_seen_r;
    pre2_nxt = pre2_seen_r;
    to_nxt = watchdog_expired_bit;
    pdf_nxt = sleep_entered_bit;
    irq_ret = 1'b0;
    sum = 9'h000;
    lo_sum = 5'h00;
    if (exec) begin
      pre1_nxt = 1'b0;
      pre2_nxt = 1'b0;
      case (op)
        `MIE_OP_MOV_AM: acc_nxt = dm_rdata;
        `MIE_OP_MOV_MA: begin
          mem_nxt = working_register;
          mem_we = 1'b1;
        end
        `MIE_OP_MOV_AX: acc_nxt = imm;
        `MIE_OP_CLRB, `MIE_OP_SETB: begin
          mem_nxt[bit_idx] = (op == `MIE_OP_SETB);
          mem_we = 1'b1;
        end
        `MIE_OP_JMP: pc_nxt = target;
        `MIE_OP_SZ: skip = (dm_rdata == 8'h00);
        `MIE_OP_SZA: begin
          acc_nxt = dm_rdata;
          skip = (dm_rdata == 8'h00);
        end
        `MIE_OP_SZB: skip = !dm_rdata[bit_idx];
        `MIE_OP_SNZB: skip = dm_rdata[bit_idx];
        `MIE_OP_SIZ, `MIE_OP_SDZ, `MIE_OP_SKIP_AFTER_INCREMENT_TO_ACC, `MIE_OP_SKIP_AFTER_DECREMENT_TO_ACC: begin
          if (op == `MIE_OP_SIZ || op == `MIE_OP_SKIP_AFTER_INCREMENT_TO_ACC)
            mem_nxt = dm_rdata + 8'h01;
          else
            mem_nxt = dm_rdata - 8'h01;
          skip = (mem_nxt == 8'h00);
          if (op == `MIE_OP_SKIP_AFTER_INCREMENT_TO_ACC || op == `MIE_OP_SKIP_AFTER_DECREMENT_TO_ACC) begin
            acc_nxt = mem_nxt;
          end else begin
            mem_we = 1'b1;
          end
        end
        `MIE_OP_CALL: begin
          push = 1'b1;
          pc_nxt = target;
        end
        `MIE_OP_RET, `MIE_OP_RETAX, `MIE_OP_RETURN_FROM_IRQ: begin
          pop = 1'b1;
          pc_nxt = stack_top;
          if (op == `MIE_OP_RETAX)
            acc_nxt = imm;
          irq_ret = (op == `MIE_OP_RETURN_FROM_IRQ);
        end
        `MIE_OP_TRDC, `MIE_OP_TRDL: begin
          // table word arrives in the dummy cycle; address set below
          state_nxt = S_DUMMY;
          pc_nxt = pc_r;
        end
        `MIE_OP_CLRM, `MIE_OP_SETM: begin
          mem_nxt = (op == `MIE_OP_SETM) ? 8'hFF : 8'h00;
          mem_we = 1'b1;
        end
        `MIE_OP_CLRWDT: begin
          wdt_clr = 1'b1;
          to_nxt = 1'b0;
          pdf_nxt = 1'b0;
        end
        // the pair works in either order; a repeat only re-arms its half
        `MIE_OP_WDT1: begin
          if (pre2_seen_r) begin
            wdt_clr = 1'b1;
            to_nxt = 1'b0;
            pdf_nxt = 1'b0;
          end else begin
            pre1_nxt = 1'b1;
          end
        end
        `MIE_OP_WDT2: begin
          if (pre1_seen_r) begin
            wdt_clr = 1'b1;
            to_nxt = 1'b0;
            pdf_nxt = 1'b0;
          end else begin
            pre2_nxt = 1'b1;
          end
        end
        `MIE_OP_SWAP, `MIE_OP_NIBBLE_EXCHANGE_TO_ACC: begin
          mem_nxt = {dm_rdata[3:0], dm_rdata[7:4]};
          if (op == `MIE_OP_NIBBLE_EXCHANGE_TO_ACC)
            acc_nxt = mem_nxt;
          else
            mem_we = 1'b1;
        end
        `MIE_OP_HALT: begin
          wdt_clr = 1'b1;
          to_nxt = 1'b0;
          pdf_nxt = 1'b1;
          state_nxt = S_HALT;
        end
        `MIE_OP_ADD, `MIE_OP_ADC: begin
          // immediate applies to both plain add and add with carry
          sum = {1'b0, working_register} + {1'b0, opnd} +
            {8'h00, (op == `MIE_OP_ADC) & c_r};
          lo_sum = {1'b0, working_register[3:0]} + {1'b0, opnd[3:0]} +
            {4'h0, (op == `MIE_OP_ADC) & c_r};
          c_nxt = sum[8];
          ac_nxt = lo_sum[4];
          z_nxt = (sum[7:0] == 8'h00);
          ov_nxt = (working_register[7] == opnd[7]) &&
            (sum[7] != opnd[7]);
          mem_nxt = sum[7:0];
          if (to_mem && !use_imm)
            mem_we = 1'b1;
          else
            acc_nxt = sum[7:0];
        end
        `MIE_OP_AND: begin
          mem_nxt = working_register & opnd;
          z_nxt = (mem_nxt == 8'h00);
          if (to_mem && !use_imm)
            mem_we = 1'b1;
          else
            acc_nxt = mem_nxt;
        end
        default: ;
      endcase
      if (skip) begin
        pc_nxt = pc_r + 2'd2;
        state_nxt = S_DUMMY;
      end
      if (op == `MIE_OP_JMP || op == `MIE_OP_CALL || pop)
        state_nxt = S_DUMMY;
      if (mem_we && imm == `MIE_PCL_ADDR) begin
        pc_nxt = {pc_r[AW-1:8], mem_nxt};
        state_nxt = S_DUMMY;
      end
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= S_EXEC;
      pc_r <= `MIE_RESET_PC;
      pm_addr_r <= {AW{1'b0}};
      dm_addr_r <= 8'h00;
      dm_wdata_r <= 8'h00;
      dm_we_r <= 1'b0;
      working_register <= 8'h00;
      {c_r, half_carry_bit, z_r, signed_wrap_bit} <= 4'h0;
      watchdog_expired_bit <= 1'b0;
      sleep_entered_bit <= 1'b0;
      pre1_seen_r <= 1'b0;
      pre2_seen_r <= 1'b0;
      watchdog_counter <= {WDT_W{1'b0}};
      clk_stopped_r <= 1'b0;
      lookup_high_byte <= 8'h00;
      return_from_irq_r <= 1'b0;
      run_r <= 1'b0;
      instr_r <= 16'h0000;
      instr_pend_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      dm_we_r <= 1'b0;
      return_from_irq_r <= irq_ret;
      if (wb_req) begin
        wb_dat_o <= 32'h0000_0000;
        case (wb_adr_i)
          `MIE_REG_CTRL: wb_dat_o <= {31'h0, run_r};
          `MIE_REG_INSTR: wb_dat_o <= {16'h0, instr_r};
          `MIE_REG_ACC: wb_dat_o <= {24'h0, working_register};
          `MIE_REG_STAT: wb_dat_o <= {16'h0, lookup_high_byte, status_byte};
          default: ;
        endcase
        if (wb_we_i && wb_adr_i == `MIE_REG_CTRL && wb_sel_i[0])
          run_r <= wb_dat_i[`MIE_CTRL_RUN];
        // a new instruction while one is pending replaces it
        if (wb_we_i && wb_adr_i == `MIE_REG_INSTR && &wb_sel_i[1:0]) begin
          instr_r <= wb_dat_i[15:0];
          instr_pend_r <= 1'b1;
          dm_addr_r <= wb_dat_i[7:0];
        end
      end
      if (!clk_stopped_r)
        watchdog_counter <= watchdog_counter + 1'b1;
      if (wdt_clr)
        watchdog_counter <= {WDT_W{1'b0}};
      case (state_r)
        S_EXEC: begin
          if (exec) begin
            instr_pend_r <= 1'b0;
            working_register <= acc_nxt;
            {c_r, half_carry_bit, z_r, signed_wrap_bit} <=
              {c_nxt, ac_nxt, z_nxt, ov_nxt};
            watchdog_expired_bit <= to_nxt;
            sleep_entered_bit <= pdf_nxt;
            pre1_seen_r <= pre1_nxt;
            pre2_seen_r <= pre2_nxt;
            pc_r <= pc_nxt;
            pm_addr_r <= pc_nxt;
            dm_we_r <= mem_we;
            dm_wdata_r <= mem_nxt;
            if (op == `MIE_OP_TRDC)
              pm_addr_r <= {pc_r[AW-1:8], working_register};
            if (op == `MIE_OP_TRDL)
              pm_addr_r <= {{(AW-8){1'b1}}, working_register};
            if (state_nxt == S_HALT)
              clk_stopped_r <= 1'b1;
            state_r <= state_nxt;
          end
        end
        S_DUMMY: begin
          if (op == `MIE_OP_TRDC || op == `MIE_OP_TRDL) begin
            lookup_high_byte <= pm_data[15:8];
            dm_wdata_r <= pm_data[7:0];
            dm_we_r <= 1'b1;
            pc_r <= pc_r + 1'b1;
            pm_addr_r <= pc_r + 1'b1;
          end
          state_r <= S_EXEC;
        end
        S_HALT: begin
          // only reset wakes the core; wake sources are outside this block
          state_r <= S_HALT;
        end
        default: state_r <= S_EXEC;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> testbench/mie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model (
  // clock
  input wire logic core_clk,
  // program memory
  input wire logic [10:0] pm_addr_r,
  output logic [15:0] pm_data,
  // data memory
  input wire logic [7:0] dm_addr_r,
  input wire logic [7:0] dm_wdata_r,
  input wire logic dm_we_r,
  output logic [7:0] dm_rdata
);
  logic [7:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
  end
  // high half differs from low half so swapped halves show up
  assign pm_data = {pm_addr_r[7:0] ^ 8'hA5, pm_addr_r[7:0]};
  // async read, as the core expects a same-cycle answer
  assign dm_rdata = mem[dm_addr_r];
  always @(posedge core_clk) begin
    if (dm_we_r) begin
      mem[dm_addr_r] <= dm_wdata_r;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/mie_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mie_core_props #(
  parameter AW = 11,
  parameter WDT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // watched signals
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic dm_we_r,
  input wire logic [WDT_W-1:0] watchdog_counter,
  input wire logic clk_stopped_r,
  input wire logic return_from_irq_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("late ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_no_stray;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray ack");
  property p_halt_holds;
    clk_stopped_r |=> clk_stopped_r;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("woke");
  property p_halt_wdt;
    clk_stopped_r |=> watchdog_counter == '0;
  endproperty
  a_halt_wdt: assert property (p_halt_wdt) else $error("wdt runs");
  property p_halt_mem;
    clk_stopped_r |=> !dm_we_r;
  endproperty
  a_halt_mem: assert property (p_halt_mem) else $error("write");
  // the count only steps by one or clears; any other jump is a slip
  property p_wdt_step;
    !$stable(watchdog_counter) |-> watchdog_counter == '0 ||
      watchdog_counter == WDT_W'($past(watchdog_counter) + 1'b1);
  endproperty
  a_wdt_step: assert property (p_wdt_step) else $error("wdt jump");
  property p_irq_pulse;
    return_from_irq_r |=> !return_from_irq_r;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq");
endmodule
bind mie_core mie_core_props #(.AW(AW), .WDT_W(WDT_W)) i_props (
  .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dm_we_r,
  .watchdog_counter, .clk_stopped_r, .return_from_irq_r
);
`default_nettype wire

// >>> testbench/mie_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
module mie_core_tb_top;
  logic core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [10:0] pm_addr_r;
  logic [15:0] pm_data, watchdog_counter;
  logic [7:0] dm_addr_r, dm_wdata_r, dm_rdata, lookup_high_byte;
  logic dm_we_r, clk_stopped_r, return_from_irq_r;
  int n_fail = 0;
  int tests_run = 0;
  int n_return_from_irq = 0;
  mie_core i_dut (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pm_addr_r,
    .pm_data, .dm_addr_r, .dm_wdata_r, .dm_we_r, .dm_rdata,
    .watchdog_counter, .clk_stopped_r, .lookup_high_byte,
    .return_from_irq_r);
  mie_mem_model i_mem (.core_clk, .pm_addr_r, .pm_data, .dm_addr_r,
    .dm_wdata_r, .dm_we_r, .dm_rdata);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // the return pulse stands one cycle only, so it is counted as it happens
  always @(posedge core_clk) begin
    if (return_from_irq_r === 1'b1) begin
      n_return_from_irq++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // only the bench watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  // settle margin covers the dummy cycle and the late memory write
  task automatic ex(input logic [4:0] op, input logic [2:0] h,
    input logic [7:0] l);
    wb(1, 4'h4, {16'h0000, op, h, l});
    repeat (4) @(posedge core_clk);
  endtask
  task automatic acc_is(input logic [7:0] e);
    wb(0, 4'h8, 32'h0);
    check(rd[7:0], e);
  endtask
  task automatic flags_is(input logic [3:0] e);
    wb(0, 4'hC, 32'h0);
    check(rd[3:0], e);
  endtask
  task automatic pc_is(input logic [10:0] e);
    check(pm_addr_r, e);
  endtask
  task automatic t_arith;
    ex(`MIE_OP_MOV_AX, 3'h0, 8'h7F);
    ex(`MIE_OP_ADD, 3'h2, 8'h01);
    acc_is(8'h80);
    flags_is(4'hA);
    ex(`MIE_OP_AND, 3'h2, 8'h00);
    flags_is(4'hE);
    ex(`MIE_OP_MOV_AX, 3'h0, 8'hFF);
    ex(`MIE_OP_MOV_MA, 3'h0, 8'h10);
    flags_is(4'hE);
    ex(`MIE_OP_MOV_AX, 3'h0, 8'h01);
    ex(`MIE_OP_ADD, 3'h4, 8'h10);
    check(i_mem.mem[8'h10], 8'h00);
    flags_is(4'h7);
    ex(`MIE_OP_ADC, 3'h0, 8'h10);
    acc_is(8'h02);
    flags_is(4'h0);
    wb(0, 4'h1, 32'h0);
    check(rd, 32'h0);
    $display("test arith done");
  endtask
  task automatic t_bits;
    ex(`MIE_OP_SETB, 3'h7, 8'h20);
    check(i_mem.mem[8'h20], 8'hA0);
    ex(`MIE_OP_CLRB, 3'h5, 8'h20);
    check(i_mem.mem[8'h20], 8'h80);
    ex(`MIE_OP_SWAP, 3'h0, 8'h20);
    check(i_mem.mem[8'h20], 8'h08);
    ex(`MIE_OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h21);
    acc_is(8'h12);
    ex(`MIE_OP_SDZ, 3'h0, 8'h01);
    check(i_mem.mem[8'h01], 8'h00);
    ex(`MIE_OP_SKIP_AFTER_INCREMENT_TO_ACC, 3'h0, 8'h22);
    acc_is(8'h23);
    ex(`MIE_OP_CLRM, 3'h0, 8'h22);
    check(i_mem.mem[8'h22], 8'h00);
    ex(`MIE_OP_SZA, 3'h0, 8'h22);
    acc_is(8'h00);
    flags_is(4'h0);
    $display("test bits done");
  endtask
  task automatic t_table;
    ex(`MIE_OP_MOV_AX, 3'h0, 8'h05);
    ex(`MIE_OP_TRDL, 3'h0, 8'h30);
    check(lookup_high_byte, 8'hA0);
    check(i_mem.mem[8'h30], 8'h05);
    $display("test table done");
  endtask
  task automatic t_flow;
    ex(`MIE_OP_JMP, 3'h1, 8'h00);
    pc_is(11'h100);
    ex(`MIE_OP_SZ, 3'h0, 8'h22);
    pc_is(11'h102);
    ex(`MIE_OP_SZ, 3'h0, 8'h21);
    pc_is(11'h103);
    ex(`MIE_OP_SZB, 3'h0, 8'h21);
    pc_is(11'h104);
    ex(`MIE_OP_SNZB, 3'h0, 8'h21);
    pc_is(11'h106);
    ex(`MIE_OP_SZB, 3'h1, 8'h21);
    pc_is(11'h108);
    ex(`MIE_OP_CALL, 3'h2, 8'hAB);
    pc_is(11'h2AB);
    ex(`MIE_OP_RETURN_FROM_IRQ, 3'h0, 8'h00);
    pc_is(11'h109);
    check(n_return_from_irq, 1);
    ex(`MIE_OP_CALL, 3'h0, 8'h50);
    pc_is(11'h050);
    ex(`MIE_OP_RETAX, 3'h0, 8'h5A);
    pc_is(11'h10A);
    acc_is(8'h5A);
    check(n_return_from_irq, 1);
    ex(`MIE_OP_MOV_MA, 3'h0, 8'h02);
    pc_is(11'h15A);
    ex(`MIE_OP_MOV_AX, 3'h0, 8'h33);
    ex(`MIE_OP_TRDC, 3'h0, 8'h31);
    check(lookup_high_byte, 8'h96);
    check(i_mem.mem[8'h31], 8'h33);
    pc_is(11'h15C);
    $display("test flow done");
  endtask
  task automatic t_wdt;
    ex(`MIE_OP_CLRWDT, 3'h0, 8'h00);
    check(watchdog_counter < 16, 1);
    repeat (40) @(posedge core_clk);
    ex(`MIE_OP_WDT1, 3'h0, 8'h00);
    ex(`MIE_OP_WDT1, 3'h0, 8'h00);
    check(watchdog_counter > 40, 1);
    ex(`MIE_OP_WDT2, 3'h0, 8'h00);
    check(watchdog_counter < 16, 1);
    repeat (40) @(posedge core_clk);
    ex(`MIE_OP_WDT2, 3'h0, 8'h00);
    ex(`MIE_OP_WDT2, 3'h0, 8'h00);
    check(watchdog_counter > 40, 1);
    ex(`MIE_OP_WDT1, 3'h0, 8'h00);
    check(watchdog_counter < 16, 1);
    ex(`MIE_OP_HALT, 3'h0, 8'h00);
    check(clk_stopped_r, 1'b1);
    check(watchdog_counter, 16'h0000);
    wb(0, 4'hC, 32'h0);
    check(rd[5:4], 2'b01);
    ex(`MIE_OP_MOV_AX, 3'h0, 8'h77);
    acc_is(8'h33);
    $display("test watchdog done");
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out;
  end
  initial begin
    sys_rst <= 1;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
    wb_adr_i <= 4'h0;
    wb_sel_i <= 4'hF;
    wb_dat_i <= 32'h0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    wb(1, 4'h0, 32'h1);
    t_arith;
    t_bits;
    t_table;
    t_flow;
    t_wdt;
    close_out;
  end
endmodule
`default_nettype wire
